// ===== tsw_pkg.sv
// constants and state encoding for the hardware task switch timer
package tsw_pkg;

	// ==========================================================
	// sizes
	localparam int NUM_TASKS = 4;
	localparam int TASK_W = 2;
	localparam int TIMER_W = 8;
	localparam int CNT_W = 4;
	localparam int DIV_W = 5;

	// ==========================================================
	// sequence timing in execution cycles
	localparam logic [CNT_W-1:0] SEQ_LAST = 4'hA;   // 11 cycles: 0..10
	localparam logic [CNT_W-1:0] SAVE_LAST = 4'h4;  // 5 cycles: 0..4

	// ==========================================================
	// count clock divider terminal counts
	localparam logic [DIV_W-1:0] DIV16_LAST = 5'h0F;
	localparam logic [DIV_W-1:0] DIV32_LAST = 5'h1F;

	// ==========================================================
	// next-task field and reset values
	localparam int NEXT_LSB = 0;
	localparam logic [NUM_TASKS-1:0] RST_TASK_EN = 4'h1;
	localparam logic [TIMER_W-1:0] RST_TIMER = 8'h00;
	localparam logic [TIMER_W-1:0] RST_PRESET = 8'h00;
	localparam logic RST_BCEN = 1'b1;
	localparam logic [TASK_W-1:0] RST_TASK = 2'h0;

	// ==========================================================
	// sequencer states
	typedef enum logic [1:0] {
		TSW_IDLE = 2'b00,
		TSW_SEQ = 2'b01,
		TSW_SAVE = 2'b10
	} tsw_state_t;

endpackage

// ===== tsw_preset_mem.sv
// per-task slice preset storage with registered read data
module tsw_preset_mem (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic wr_en_in,
	input wire logic [tsw_pkg::TASK_W-1:0] wr_addr_in,
	input wire logic [tsw_pkg::TIMER_W-1:0] wr_data_in,
	input wire logic [tsw_pkg::TASK_W-1:0] rd_addr_in,
	output logic [tsw_pkg::TIMER_W-1:0] rd_data_out
);

	// ==========================================================
	// state
	typedef struct packed {
		logic [tsw_pkg::NUM_TASKS-1:0][tsw_pkg::TIMER_W-1:0] word;
		logic [tsw_pkg::TIMER_W-1:0] rd;
	} tsw_mem_t;

	tsw_mem_t q;
	tsw_mem_t d;

	// write port and read register; read shows old word on a colliding write
	always_comb begin
		d = q;
		d.rd = q.word[rd_addr_in];
		if (wr_en_in) begin
			d.word[wr_addr_in] = wr_data_in;
		end
	end

	// registered copy
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			q <= '{word: {tsw_pkg::NUM_TASKS{tsw_pkg::RST_PRESET}}, rd: tsw_pkg::RST_PRESET};
		end else begin
			q <= d;
		end
	end

	assign rd_data_out = q.rd;

endmodule

// ===== tsw_task_switch.sv
// task switch sequencer with per-task slice timer
module tsw_task_switch (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic irq_active_in,
	input wire logic task_en_wr_in,
	input wire logic [tsw_pkg::NUM_TASKS-1:0] task_en_wdata_in,
	input wire logic next_task_wr_in,
	input wire logic [7:0] next_task_wdata_in,
	input wire logic slice_wr_in,
	input wire logic [tsw_pkg::TIMER_W-1:0] slice_wdata_in,
	input wire logic preset_wr_in,
	input wire logic [tsw_pkg::TASK_W-1:0] preset_idx_in,
	input wire logic [tsw_pkg::TIMER_W-1:0] preset_wdata_in,
	input wire logic bcen_wr_in,
	input wire logic bcen_wdata_in,
	input wire logic div32_sel_in,
	output logic [tsw_pkg::TASK_W-1:0] current_task_out,
	output logic [tsw_pkg::NUM_TASKS-1:0] task_enable_out,
	output logic [tsw_pkg::TIMER_W-1:0] slice_timer_out,
	output logic slice_count_enable_out,
	output logic switch_busy_out,
	output logic switch_start_out,
	output logic save_block_out,
	output logic irq_sp_sel_out
);

	// ==========================================================
	// helpers
	function automatic logic multi_enabled(input logic [tsw_pkg::NUM_TASKS-1:0] en);
		int n;
		n = 0;
		for (int i = 0; i < tsw_pkg::NUM_TASKS; i++) begin
			n = n + int'(en[i]);
		end
		return n > 1;
	endfunction

	// next enabled task above cur, wrapping; falls back to cur
	function automatic logic [tsw_pkg::TASK_W-1:0] next_enabled(
		input logic [tsw_pkg::TASK_W-1:0] cur,
		input logic [tsw_pkg::NUM_TASKS-1:0] en
	);
		logic [tsw_pkg::TASK_W-1:0] pick;
		logic [tsw_pkg::TASK_W-1:0] cand;
		logic found;
		pick = cur;
		found = 1'b0;
		for (int k = 1; k < tsw_pkg::NUM_TASKS; k++) begin
			cand = cur + k[tsw_pkg::TASK_W-1:0];
			if (!found && en[cand]) begin
				pick = cand;
				found = 1'b1;
			end
		end
		return pick;
	endfunction

	// at least one task always stays enabled
	function automatic logic [tsw_pkg::NUM_TASKS-1:0] force_task0(
		input logic [tsw_pkg::NUM_TASKS-1:0] en
	);
		logic [tsw_pkg::NUM_TASKS-1:0] r;
		r = en;
		if (en[tsw_pkg::NUM_TASKS-1:1] == '0) begin
			r[0] = 1'b1;
		end
		return r;
	endfunction

	// ==========================================================
	// state
	typedef struct packed {
		tsw_pkg::tsw_state_t state;
		logic [tsw_pkg::CNT_W-1:0] cnt;
		logic [tsw_pkg::DIV_W-1:0] div;
		logic [tsw_pkg::TIMER_W-1:0] timer;
		logic [tsw_pkg::TASK_W-1:0] cur;
		logic [tsw_pkg::TASK_W-1:0] target;
		logic [tsw_pkg::NUM_TASKS-1:0] en;
		logic bcen;
		logic pend;
		logic [tsw_pkg::TASK_W-1:0] pend_task;
		logic busy;
		logic start;
		logic save_blk;
		logic irq_sp;
	} tsw_regs_t;

	tsw_regs_t q;
	tsw_regs_t d;

	logic [tsw_pkg::TIMER_W-1:0] preset_rd;
	logic tick;
	logic count_en;
	logic uf;
	logic [tsw_pkg::TASK_W-1:0] wr_task;

	// ==========================================================
	// preset storage, read address follows the task being entered
	tsw_preset_mem u_preset (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.wr_en_in(preset_wr_in),
		.wr_addr_in(preset_idx_in),
		.wr_data_in(preset_wdata_in),
		.rd_addr_in(q.target),
		.rd_data_out(preset_rd)
	);

	// ==========================================================
	// count tick, underflow and write decode
	always_comb begin
		tick = div32_sel_in ? (q.div == tsw_pkg::DIV32_LAST)
			: (q.div[3:0] == tsw_pkg::DIV16_LAST[3:0]);
		// timer frozen outside idle, in service, single task or halted
		count_en = tick && (q.state == tsw_pkg::TSW_IDLE) && !irq_active_in
			&& multi_enabled(q.en) && q.bcen;
		uf = count_en && (q.timer == '0);
		wr_task = next_task_wdata_in[tsw_pkg::NEXT_LSB +: tsw_pkg::TASK_W];
	end

	// ==========================================================
	// sequencer and timer next state
	always_comb begin
		d = q;
		d.start = 1'b0;
		d.irq_sp = irq_active_in;
		d.div = q.div + 5'h01;
		// divider restarts at the selected rate's terminal count (/16 or /32) so both rates share one counter
		if (tick) begin
			d.div = '0;
		end
		if (count_en) begin
			d.timer = q.timer - 8'h01;
		end
		if (slice_wr_in) begin
			d.timer = slice_wdata_in;
		end
		if (bcen_wr_in) begin
			d.bcen = bcen_wdata_in;
		end
		// enable bits recorded in every state, even while switching
		if (task_en_wr_in) begin
			d.en = force_task0(task_en_wdata_in);
		end
		// selection during service waits for the return
		if (next_task_wr_in && irq_active_in) begin
			d.pend = 1'b1;
			d.pend_task = wr_task;
		end
		unique case (q.state)
			tsw_pkg::TSW_IDLE: begin
				if (!irq_active_in && next_task_wr_in) begin
					// write wins over a coincident underflow: one sequence
					d.state = tsw_pkg::TSW_SEQ;
					d.target = wr_task;
					// a fresh selection supersedes any one left from service
					d.pend = 1'b0;
				end else if (!irq_active_in && q.pend) begin
					d.state = tsw_pkg::TSW_SEQ;
					d.target = q.pend_task;
					d.pend = 1'b0;
				end else if (uf) begin
					d.state = tsw_pkg::TSW_SEQ;
					d.target = next_enabled(q.cur, q.en);
				end
				if (d.state == tsw_pkg::TSW_SEQ) begin
					d.cnt = '0;
					d.busy = 1'b1;
					d.start = 1'b1;
				end
			end
			tsw_pkg::TSW_SEQ: begin
				// no count runs here, so a late underflow cannot retrigger
				d.cnt = q.cnt + 4'h1;
				if (q.cnt == tsw_pkg::SEQ_LAST) begin
					d.state = tsw_pkg::TSW_SAVE;
					d.cnt = '0;
					d.busy = 1'b0;
					d.save_blk = 1'b1;
					d.cur = q.target;
					d.timer = preset_rd;
				end
			end
			tsw_pkg::TSW_SAVE: begin
				// next-task writes here outside service are dropped, not queued
				d.cnt = q.cnt + 4'h1;
				if (q.cnt == tsw_pkg::SAVE_LAST) begin
					d.state = tsw_pkg::TSW_IDLE;
					d.save_blk = 1'b0;
				end
			end
			default: begin
				d.state = tsw_pkg::TSW_IDLE;
			end
		endcase
	end

	// ==========================================================
	// registered copy
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			q <= '{state: tsw_pkg::TSW_IDLE, cnt: '0, div: '0, timer: tsw_pkg::RST_TIMER,
				cur: tsw_pkg::RST_TASK, target: tsw_pkg::RST_TASK, en: tsw_pkg::RST_TASK_EN,
				bcen: tsw_pkg::RST_BCEN, pend: 1'b0, pend_task: tsw_pkg::RST_TASK,
				busy: 1'b0, start: 1'b0, save_blk: 1'b0, irq_sp: 1'b0};
		end else begin
			q <= d;
		end
	end

	// ==========================================================
	// outputs, all from flops
	assign current_task_out = q.cur;
	assign task_enable_out = q.en;
	assign slice_timer_out = q.timer;
	assign slice_count_enable_out = q.bcen;
	assign switch_busy_out = q.busy;
	assign switch_start_out = q.start;
	assign save_block_out = q.save_blk;
	assign irq_sp_sel_out = q.irq_sp;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (srst_in);

	property p_seq_len;
		$rose(q.busy) |-> ##10 q.busy ##1 !q.busy;
	endproperty
	a_seq_len: assert property (p_seq_len) else $error("switch sequence not 11 cycles");

	property p_save_blk;
		$fell(q.busy) |-> q.save_blk[*5] ##1 !q.save_blk;
	endproperty
	a_save_blk: assert property (p_save_blk) else $error("save block not 5 cycles");

	property p_reload;
		$fell(q.busy) |-> (q.timer == $past(preset_rd)) && (q.cur == $past(q.target));
	endproperty
	a_reload: assert property (p_reload) else $error("timer not reloaded from preset");

	property p_irq_hold;
		irq_active_in && !slice_wr_in && q.state == tsw_pkg::TSW_IDLE |=> q.timer == $past(q.timer);
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("timer moved during service");

	property p_irq_noswitch;
		irq_active_in && q.state == tsw_pkg::TSW_IDLE |=> q.state != tsw_pkg::TSW_SEQ;
	endproperty
	a_irq_noswitch: assert property (p_irq_noswitch) else $error("switch during service");

	property p_same_cycle;
		q.state == tsw_pkg::TSW_IDLE && !irq_active_in && next_task_wr_in && uf
			|=> q.busy && q.target == $past(wr_task) ##1 q.busy;
	endproperty
	a_same_cycle: assert property (p_same_cycle) else $error("wrong target on collision");

	property p_save_ignore;
		q.state == tsw_pkg::TSW_SAVE && q.cnt != tsw_pkg::SAVE_LAST |=> !q.busy;
	endproperty
	a_save_ignore: assert property (p_save_ignore) else $error("switch started in save");

	property p_halt;
		(!q.bcen || !multi_enabled(q.en)) && !slice_wr_in && q.state == tsw_pkg::TSW_IDLE
			|=> q.timer == $past(q.timer);
	endproperty
	a_halt: assert property (p_halt) else $error("halted timer changed");

	property p_force0;
		q.en[tsw_pkg::NUM_TASKS-1:1] == '0 |-> q.en[0];
	endproperty
	a_force0: assert property (p_force0) else $error("no task enabled");

	property p_irq_sp;
		irq_active_in |=> irq_sp_sel_out;
	endproperty
	a_irq_sp: assert property (p_irq_sp) else $error("task stack used in service");

	property p_start_pulse;
		q.start |=> !q.start && q.busy;
	endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("start pulse not single");

	property p_pend_fire;
		q.pend && q.state == tsw_pkg::TSW_IDLE && !irq_active_in && !next_task_wr_in
			|=> q.busy && q.target == $past(q.pend_task);
	endproperty
	a_pend_fire: assert property (p_pend_fire) else $error("held selection not taken");

	property p_count_step;
		count_en && !slice_wr_in |=> q.timer == $past(q.timer) - 8'h01;
	endproperty
	a_count_step: assert property (p_count_step) else $error("timer step wrong");

	property p_uf_start;
		uf |=> q.busy;
	endproperty
	a_uf_start: assert property (p_uf_start) else $error("underflow did not switch");

	property p_write_start;
		q.state == tsw_pkg::TSW_IDLE && !irq_active_in && next_task_wr_in
			|=> q.busy && q.target == $past(next_task_wdata_in[1:0]);
	endproperty
	a_write_start: assert property (p_write_start) else $error("next task write not taken");

	property p_seq_freeze;
		q.state == tsw_pkg::TSW_SEQ && q.cnt != tsw_pkg::SEQ_LAST && !slice_wr_in
			|=> q.timer == $past(q.timer);
	endproperty
	a_seq_freeze: assert property (p_seq_freeze) else $error("timer moved in sequence");

endmodule

// ===== tsw_core_model.sv
// behavioural model of the core's interrupt service window
module tsw_core_model (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic svc_req_in,
	input wire logic [7:0] svc_len_in,
	output logic irq_active_out
);
	logic [7:0] left_q;

	// ==========================================================
	// service window
	// one service at a time; a request while busy is simply not taken, which is the
	// outcome for a lower-priority source under a higher-priority one
	// sampled on the rising edge, so a request set at the falling edge is never raced
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			left_q <= 8'h00;
		end else if (left_q != 8'h00) begin
			left_q <= left_q - 8'h01;
		end else if (svc_req_in) begin
			left_q <= svc_len_in;
		end
	end
	// task suspended while high, resumed when it falls
	assign irq_active_out = (left_q != 8'h00);
endmodule

// ===== hardware_task_switch_timer_tb_top.sv
// self-checking bench for the task switch sequencer
module hardware_task_switch_timer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in = 1'b0, srst_in = 1'b1, task_en_wr_in = 1'b0, next_task_wr_in = 1'b0, slice_wr_in = 1'b0;
	logic preset_wr_in = 1'b0, bcen_wr_in = 1'b0, bcen_wdata_in = 1'b0, div32_sel_in = 1'b0;
	logic svc_req = 1'b0, irq_active, switch_busy_out, switch_start_out, save_block_out, irq_sp_sel_out;
	logic slice_count_enable_out, irq_d = 1'b0;
	logic [3:0] task_en_wdata_in = 4'h0, task_enable_out;
	logic [7:0] next_task_wdata_in = 8'h00, slice_wdata_in = 8'h00, preset_wdata_in = 8'h00, slice_timer_out, v;
	logic [1:0] preset_idx_in = 2'h0, current_task_out, t;
	logic [7:0] pre [4];
	logic [31:0] rs = 32'hFB77839B;
	int n_mismatch = 0, n_compared = 0, cyc = 0, p;

	tsw_task_switch DUT (.clk_in(clk_in), .srst_in(srst_in), .irq_active_in(irq_active),
		.task_en_wr_in(task_en_wr_in), .task_en_wdata_in(task_en_wdata_in), .next_task_wr_in(next_task_wr_in),
		.next_task_wdata_in(next_task_wdata_in), .slice_wr_in(slice_wr_in), .slice_wdata_in(slice_wdata_in),
		.preset_wr_in(preset_wr_in), .preset_idx_in(preset_idx_in), .preset_wdata_in(preset_wdata_in),
		.bcen_wr_in(bcen_wr_in), .bcen_wdata_in(bcen_wdata_in), .div32_sel_in(div32_sel_in),
		.current_task_out(current_task_out), .task_enable_out(task_enable_out), .slice_timer_out(slice_timer_out),
		.slice_count_enable_out(slice_count_enable_out), .switch_busy_out(switch_busy_out),
		.switch_start_out(switch_start_out), .save_block_out(save_block_out), .irq_sp_sel_out(irq_sp_sel_out));
	tsw_core_model core (.clk_in(clk_in), .srst_in(srst_in), .svc_req_in(svc_req), .svc_len_in(8'h50),
		.irq_active_out(irq_active));

	// ==========================================================
	// clock, watchdog, helpers
	always #2 clk_in = ~clk_in;
	// generous ceiling: the longest wait is one full slice at /32
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		irq_d <= irq_active;
		if (cyc == 30000) begin
			n_mismatch++;
			test_done();
		end
	end
	function automatic logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	// next enabled task above the current one, wrapping
	function automatic logic [1:0] nxt(input logic [1:0] c, input logic [3:0] e);
		logic [1:0] k;
		k = c;
		for (int i = 0; i < 4; i++) begin
			k = k + 2'h1;
			if (e[k]) return k;
		end
		return c;
	endfunction
	task automatic chk(input logic [7:0] s, input logic [7:0] e, input string m);
		n_compared++;
		if (s !== e) begin
			n_mismatch++;
			$display("ERROR %0t %s seen %h exp %h", $time, m, s, e);
		end
	endtask
	// one-cycle write pulse: 0 enables, 1 next task, 2 timer, 3 preset, 4 count enable
	task automatic wr(input int k, input logic [7:0] d, input logic [1:0] i);
		@(negedge clk_in);
		case (k)
			0: begin task_en_wr_in = 1'b1; task_en_wdata_in = d[3:0]; end
			1: begin next_task_wr_in = 1'b1; next_task_wdata_in = d; end
			2: begin slice_wr_in = 1'b1; slice_wdata_in = d; end
			3: begin preset_wr_in = 1'b1; preset_wdata_in = d; preset_idx_in = i; end
			default: begin bcen_wr_in = 1'b1; bcen_wdata_in = d[0]; end
		endcase
		@(negedge clk_in);
		{task_en_wr_in, next_task_wr_in, slice_wr_in, preset_wr_in, bcen_wr_in} = 5'h00;
	endtask
	task automatic wait_start();
		int k;
		k = 0;
		while (switch_start_out !== 1'b1 && k < 5000) begin
			@(negedge clk_in);
			k++;
		end
		chk({7'h0, switch_start_out}, 8'h01, "no switch started");
	endtask
	// follow one sequence; optionally poke a next-task write in the first save cycle
	task automatic sw_check(input logic [1:0] tg, input logic poke);
		int n;
		n = 0;
		while (switch_busy_out === 1'b1 && n < 40) begin
			@(negedge clk_in);
			n++;
		end
		chk(n[7:0], 8'd11, "sequence length");
		chk({6'h0, current_task_out}, {6'h0, tg}, "entered task");
		chk(slice_timer_out, pre[tg], "reload value");
		n = 0;
		while (save_block_out === 1'b1 && n < 40) begin
			next_task_wr_in = poke && n == 0;
			next_task_wdata_in = {6'h00, tg + 2'h1};
			@(negedge clk_in);
			n++;
		end
		next_task_wr_in = 1'b0;
		chk(n[7:0], 8'd5, "save window");
		@(negedge clk_in);
		chk({7'h0, switch_busy_out}, 8'h00, "write in save window taken");
	endtask
	// cycles between two count ticks, and the step size
	task automatic period(input logic s);
		div32_sel_in = s;
		for (int j = 0; j < 2; j++) begin
			v = slice_timer_out;
			p = 0;
			while (slice_timer_out === v && p < 80) begin
				@(negedge clk_in);
				p++;
			end
		end
		chk(p[7:0], s ? 8'd32 : 8'd16, "tick period");
		chk(v - slice_timer_out, 8'h01, "decrement step");
	endtask
	task automatic test_done();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ==========================================================
	// main sequence
	initial begin
		repeat (3) @(negedge clk_in);
		srst_in = 1'b0;
		repeat (40) @(negedge clk_in);
		chk({6'h0, current_task_out}, 8'h00, "reset task");
		chk({4'h0, task_enable_out}, 8'h01, "reset enables");
		chk(slice_timer_out, 8'h00, "timer stopped with one task");
		for (int i = 0; i < 4; i++) begin
			pre[i] = {4'h0, xs() & 32'hF} + 8'h01;
			wr(3, pre[i], i[1:0]);
		end
		wr(0, 8'h00, 2'h0);
		chk({4'h0, task_enable_out}, 8'h01, "task 0 kept enabled");
		$display("reset and enable tests done");
		wr(0, 8'h0B, 2'h0);
		t = 2'h0;
		for (int i = 0; i < 4; i++) begin
			t = nxt(t, 4'hB);
			wait_start();
			sw_check(t, 1'b0);
		end
		$display("timer switch tests done");
		wr(4, 8'h00, 2'h0);
		v = slice_timer_out;
		repeat (70) @(negedge clk_in);
		chk({7'h0, slice_count_enable_out}, 8'h00, "count enable cleared");
		chk(slice_timer_out, v, "halted timer moved");
		wr(2, 8'h80, 2'h0);
		chk(slice_timer_out, 8'h80, "software timer write");
		wr(4, 8'h01, 2'h0);
		period(1'b0);
		period(1'b1);
		$display("count clock tests done");
		// stop the count before selecting a task, so no underflow can interfere
		wr(4, 8'h00, 2'h0);
		t = xs() & 32'h3;
		wr(1, {xs() & 32'hFC} | {6'h0, t}, 2'h0);
		wait_start();
		sw_check(t, 1'b1);
		$display("next task write tests done");
		wr(4, 8'h01, 2'h0);
		@(negedge clk_in);
		svc_req = 1'b1;
		@(negedge clk_in);
		svc_req = 1'b0;
		v = slice_timer_out;
		t = (current_task_out == 2'h3) ? 2'h1 : 2'h3;
		wr(1, {6'h00, t}, 2'h0);
		for (int i = 0; i < 60; i++) begin
			@(negedge clk_in);
			chk({7'h0, irq_sp_sel_out}, {7'h0, irq_d}, "interrupt stack select");
			chk({7'h0, switch_busy_out}, 8'h00, "switch during service");
		end
		chk(slice_timer_out, v, "timer moved during service");
		wait_start();
		sw_check(t, 1'b0);
		$display("interrupt tests done");
		// write lands on the very edge of an underflow: one sequence, write's target
		wr(2, 8'h00, 2'h0);
		p = 0;
		while (DUT.uf !== 1'b1 && p < 80) begin
			@(negedge clk_in);
			p++;
		end
		next_task_wr_in = 1'b1;
		next_task_wdata_in = 8'h02;
		@(negedge clk_in);
		next_task_wr_in = 1'b0;
		wait_start();
		sw_check(2'h2, 1'b0);
		// single task keeps the count; fresh value written before the second enable
		wr(0, 8'h01, 2'h0);
		v = slice_timer_out;
		repeat (70) @(negedge clk_in);
		chk(slice_timer_out, v, "count kept with one task");
		wr(2, 8'h03, 2'h0);
		chk(slice_timer_out, 8'h03, "fresh count");
		wr(0, 8'h0B, 2'h0);
		wait_start();
		sw_check(2'h3, 1'b0);
		$display("collision and resume tests done");
		test_done();
	end
endmodule
